/* verilog/slled_pkg.sv */
// Package for strap latch and port LED control: offsets, fields, reset values, types.
// Assumes a 100 MHz system clock and a 32-bit APB register bus.
package slled_pkg;
	localparam logic [11:0] SLLED_P1_LED_CTRL_OFS = 12'h06c;
	localparam logic [11:0] SLLED_P2_LED_CTRL_OFS = 12'h084;
	localparam logic [11:0] SLLED_CHIP_CFG_OFS = 12'h100;
	localparam logic [11:0] SLLED_PORT_STATUS_OFS = 12'h104;
	localparam logic [11:0] SLLED_PWRDN_OFS = 12'h108;
	localparam int SLLED_LED_MODE_LSB = 12;
	localparam int SLLED_LED_MODE_MSB = 14;
	localparam int SLLED_LED_A_BIT = 0;
	localparam int SLLED_LED_B_BIT = 1;
	localparam int SLLED_CFG_WIDTH_LSB = 6;
	localparam int SLLED_CFG_WIDTH_MSB = 7;
	localparam int SLLED_CFG_EEPROM_BIT = 9;
	localparam int SLLED_CFG_ORDER_BIT = 10;
	localparam int SLLED_CFG_RSVD_BIT = 0;
	localparam logic [2:0] SLLED_MODE_AUTO = 3'h0;
	localparam logic [15:0] SLLED_LED_CTRL_RST = 16'h0000;
	localparam logic [15:0] SLLED_CFG_RST = 16'h0000;
	localparam logic SLLED_LED_ON = 1'h0;
	localparam logic SLLED_LED_OFF = 1'h1;
	localparam int SLLED_BLINK_NS = 50000000;
	localparam int SLLED_CLK_NS = 10;
	localparam int SLLED_BLINK_CYCLES = SLLED_BLINK_NS / SLLED_CLK_NS;
	localparam int SLLED_RESET_MIN_MS = 10;

	typedef struct packed {
		logic link;
		logic activity;
		logic speed100;
		logic fullDuplex;
	} slled_port_status_t;

	typedef struct packed {
		logic eepromPresent;
		logic bigEndian;
		logic bus8bit;
		logic reservedLow;
	} slled_straps_t;

	typedef enum logic [1:0] {
		SLLED_ST_SAMPLE,
		SLLED_ST_RUN,
		SLLED_ST_PWRDN
	} slled_state_t;
endpackage : slled_pkg

/* verilog/slled_strap_led.sv */
// Strap latch and port status LED control with APB register access.
// Assumes board pull resistors on the strap pins and a testbench that resolves pin levels from the enables.
//
// Implementation choice: the APB interface to the registers.
`timescale 1ns/1ps
module slled_strap_led
	import slled_pkg::*;
#(
	parameter int BLINK_CYCLES = SLLED_BLINK_CYCLES
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic hwPowerDown,
	input wire slled_port_status_t portOneStatus,
	input wire slled_port_status_t portTwoStatus,
	input wire logic portOneLedAIn,
	output logic portOneLedAOut,
	output logic portOneLedAOe,
	input wire logic portOneLedBIn,
	output logic portOneLedBOut,
	output logic portOneLedBOe,
	input wire logic portTwoLedAIn,
	output logic portTwoLedAOut,
	output logic portTwoLedAOe,
	output logic portTwoLedBOut,
	output logic portTwoLedBOe,
	input wire logic eepromPresentStrapIn,
	output logic eepromPresentStrapOut,
	output logic eepromPresentStrapOe,
	output logic bus8bit,
	output logic bigEndian,
	output logic eepromPresent,
	output logic reservedStrapLow,
	output logic pinsAreOutputs,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr
);
	slled_state_t stateReg, stateNext;
	slled_straps_t strapsReg, strapsNext;
	logic [15:0] p1CtrlReg, p2CtrlReg;
	logic swPowerDownReg;
	logic [31:0] blinkCntReg;
	logic blinkReg;
	logic [31:0] prdataReg;
	logic pslverrReg;

	function automatic logic [1:0] autoLeds(input slled_port_status_t st, input logic blink);
		logic linkLit;
		logic speedLit;
		linkLit = st.link & ~(st.activity & blink);
		speedLit = st.link & st.speed100;
		// Index b is link/activity, a is speed
		autoLeds = {linkLit, speedLit};
	endfunction : autoLeds

	function automatic logic [1:0] portLeds(input logic [15:0] ctrl, input slled_port_status_t st,
		input logic blink);
		logic [1:0] lit;
		lit = 2'h0;
		if (ctrl[SLLED_LED_MODE_MSB:SLLED_LED_MODE_LSB] == SLLED_MODE_AUTO) begin
			lit = autoLeds(st, blink);
		end else begin
			lit = {ctrl[SLLED_LED_B_BIT], ctrl[SLLED_LED_A_BIT]};
		end
		// Active low drive
		portLeds = ~lit;
	endfunction : portLeds

	// Duplex indicator shares port two's b pin
	wire logic [1:0] p1Drive = portLeds(p1CtrlReg, portOneStatus, blinkReg);
	wire logic [1:0] p2Drive = portLeds(p2CtrlReg, portTwoStatus, blinkReg);
	wire logic p2Auto = p2CtrlReg[SLLED_LED_MODE_MSB:SLLED_LED_MODE_LSB] == SLLED_MODE_AUTO;
	wire logic duplexLit = portOneStatus.link & portOneStatus.fullDuplex;
	wire logic p2BDrive = p2Auto ? ~duplexLit : p2Drive[1];
	wire logic running = stateReg == SLLED_ST_RUN;
	wire logic powerDown = hwPowerDown | swPowerDownReg;

	// Strap decode
	always_comb begin
		strapsNext = strapsReg;
		stateNext = stateReg;
		case (stateReg)
			SLLED_ST_SAMPLE: begin
				strapsNext.bus8bit = ~portOneLedAIn;
				strapsNext.bigEndian = ~portTwoLedAIn;
				strapsNext.eepromPresent = eepromPresentStrapIn;
				strapsNext.reservedLow = ~portOneLedBIn;
				stateNext = SLLED_ST_RUN;
			end
			SLLED_ST_RUN: begin
				if (powerDown) begin
					stateNext = SLLED_ST_PWRDN;
				end
			end
			SLLED_ST_PWRDN: begin
				if (!powerDown) begin
					stateNext = SLLED_ST_SAMPLE;
				end
			end
			default: begin
				stateNext = SLLED_ST_SAMPLE;
			end
		endcase
	end

	// First edge after reset release samples the straps
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			stateReg <= SLLED_ST_SAMPLE;
			strapsReg <= '0;
		end else begin
			stateReg <= stateNext;
			strapsReg <= strapsNext;
		end
	end

	// Blink timer
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			blinkCntReg <= 32'h0;
			blinkReg <= 1'h0;
		end else if (blinkCntReg >= 32'(BLINK_CYCLES - 1)) begin
			blinkCntReg <= 32'h0;
			blinkReg <= ~blinkReg;
		end else begin
			blinkCntReg <= blinkCntReg + 32'h1;
		end
	end

	// APB decode
	wire logic access = psel & penable;
	wire logic wrAccess = access & pwrite;
	wire logic hitP1 = paddr == SLLED_P1_LED_CTRL_OFS;
	wire logic hitP2 = paddr == SLLED_P2_LED_CTRL_OFS;
	wire logic hitCfg = paddr == SLLED_CHIP_CFG_OFS;
	wire logic hitStat = paddr == SLLED_PORT_STATUS_OFS;
	wire logic hitPd = paddr == SLLED_PWRDN_OFS;
	wire logic hitAny = hitP1 | hitP2 | hitCfg | hitStat | hitPd;
	wire logic badAccess = ~hitAny | (pwrite & (hitCfg | hitStat));
	logic [15:0] cfgWord;
	logic [31:0] readMux;

	always_comb begin
		cfgWord = SLLED_CFG_RST;
		cfgWord[SLLED_CFG_WIDTH_MSB:SLLED_CFG_WIDTH_LSB] = {2{~strapsReg.bus8bit}};
		cfgWord[SLLED_CFG_EEPROM_BIT] = strapsReg.eepromPresent;
		cfgWord[SLLED_CFG_ORDER_BIT] = ~strapsReg.bigEndian;
		cfgWord[SLLED_CFG_RSVD_BIT] = strapsReg.reservedLow;
		if (hitP1) begin
			readMux = {16'h0, p1CtrlReg};
		end else if (hitP2) begin
			readMux = {16'h0, p2CtrlReg};
		end else if (hitCfg) begin
			readMux = {16'h0, cfgWord};
		end else if (hitStat) begin
			readMux = {24'h0, portTwoStatus, portOneStatus};
		end else if (hitPd) begin
			readMux = {31'h0, swPowerDownReg};
		end else begin
			readMux = 32'h0;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			p1CtrlReg <= SLLED_LED_CTRL_RST;
			p2CtrlReg <= SLLED_LED_CTRL_RST;
			swPowerDownReg <= 1'h0;
		end else if (wrAccess) begin
			if (hitP1) begin
				p1CtrlReg <= pwdata[15:0];
			end else if (hitP2) begin
				p2CtrlReg <= pwdata[15:0];
			end else if (hitPd) begin
				swPowerDownReg <= pwdata[0];
			end
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			prdataReg <= 32'h0;
			pslverrReg <= 1'h0;
		end else begin
			prdataReg <= (psel & ~penable & ~pwrite) ? readMux : prdataReg;
			pslverrReg <= psel & ~penable & badAccess;
		end
	end

	// Zero-wait slave; read data captured in setup
	assign pready = 1'h1;
	assign prdata = prdataReg;
	assign pslverr = access & pslverrReg;

	// LED pins turn to outputs once the straps are held; the eeprom strap pin stays an input
	assign pinsAreOutputs = running;
	assign portOneLedAOe = running;
	assign portOneLedBOe = running;
	assign portTwoLedAOe = running;
	assign portTwoLedBOe = running;
	assign eepromPresentStrapOe = 1'h0;
	assign eepromPresentStrapOut = 1'h0;
	assign portOneLedAOut = running ? p1Drive[0] : SLLED_LED_OFF;
	assign portOneLedBOut = running ? p1Drive[1] : SLLED_LED_OFF;
	assign portTwoLedAOut = running ? p2Drive[0] : SLLED_LED_OFF;
	assign portTwoLedBOut = running ? p2BDrive : SLLED_LED_OFF;
	assign bus8bit = strapsReg.bus8bit;
	assign bigEndian = strapsReg.bigEndian;
	assign eepromPresent = strapsReg.eepromPresent;
	assign reservedStrapLow = strapsReg.reservedLow;
endmodule : slled_strap_led

/* test/slled_assertions.sv */
// Checker for strap latch and LED control.
// Assumes it is bound to the ports of slled_strap_led.
`timescale 1ns/1ps
module slled_chk
	import slled_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	input wire logic hwPowerDown,
	input wire slled_port_status_t portOneStatus,
	input wire logic portOneLedAIn,
	input wire logic portOneLedAOut,
	input wire logic portOneLedAOe,
	input wire logic portTwoLedAOut,
	input wire logic eepromPresentStrapIn,
	input wire logic bus8bit,
	input wire logic eepromPresent,
	input wire logic pinsAreOutputs,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	logic autoOne_reg;
	wire wrOne = psel && penable && pwrite && paddr == 12'h06c;
	wire wrTwo = psel && penable && pwrite && paddr == 12'h084;
	always_ff @(posedge clk or posedge rst) begin
		if (rst) autoOne_reg <= 1'h1;
		else if (wrOne) autoOne_reg <= pwdata[14:12] == 3'h0;
	end
	sequence s_rel;
		$past(rst) ##0 !rst;
	endsequence
	property p_in;
		disable iff (1'b0) rst |-> !portOneLedAOe;
	endproperty
	a_in: assert property (p_in) else $error("strap pin driven in reset");
	property p_wid;
		s_rel |=> bus8bit == !$past(portOneLedAIn);
	endproperty
	a_wid: assert property (p_wid) else $error("bus width latch wrong");
	property p_eep;
		s_rel |=> eepromPresent == $past(eepromPresentStrapIn);
	endproperty
	a_eep: assert property (p_eep) else $error("eeprom latch wrong");
	property p_hold;
		$past(pinsAreOutputs) && pinsAreOutputs |-> $stable({bus8bit, eepromPresent});
	endproperty
	a_hold: assert property (p_hold) else $error("latched strap changed");
	property p_pd;
		hwPowerDown |=> !pinsAreOutputs && portOneLedAOut;
	endproperty
	a_pd: assert property (p_pd) else $error("power down not entered");
	property p_man1;
		wrOne && pwdata[14:12] != 3'h0 |=> !pinsAreOutputs || portOneLedAOut == !$past(pwdata[0]);
	endproperty
	a_man1: assert property (p_man1) else $error("port one manual led wrong");
	property p_man2;
		wrTwo && pwdata[14:12] != 3'h0 |=> !pinsAreOutputs || portTwoLedAOut == !$past(pwdata[0]);
	endproperty
	a_man2: assert property (p_man2) else $error("port two manual led wrong");
	property p_auto;
		autoOne_reg && pinsAreOutputs && $stable(portOneStatus) |->
			portOneLedAOut == !(portOneStatus.speed100 && portOneStatus.link);
	endproperty
	a_auto: assert property (p_auto) else $error("auto speed led wrong");
endmodule : slled_chk
bind slled_strap_led slled_chk u_chk(.clk, .rst, .hwPowerDown, .portOneStatus, .portOneLedAIn,
	.portOneLedAOut, .portOneLedAOe, .portTwoLedAOut, .eepromPresentStrapIn, .bus8bit,
	.eepromPresent, .pinsAreOutputs, .psel, .penable, .pwrite, .paddr, .pwdata);

/* test/slled_board.sv */
// Board model: strap resistors on the four strap pins.
// Assumes pin order reserved, width, order, eeprom.
`timescale 1ns/1ps
module slled_board (
	input wire logic [3:0] strap,
	input wire logic [3:0] oe,
	input wire logic [3:0] drv,
	output logic [3:0] pin
);
	// Resistor level when released; reserved pin held high by default
	assign pin = (oe & drv) | (~oe & strap);
endmodule : slled_board

/* test/tb_top.sv */
// Bench for strap latch and LED control.
// Assumes the board model resolves the strap pins.
`timescale 1ns/1ps
module tb_top;
	import slled_pkg::*;
	logic clk, rst, hwPowerDown, psel, penable, pwrite, pready, pslverr, p2b, b8, be, ep, rl, po;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata;
	slled_port_status_t st1, st2;
	logic [3:0] strap, oe, drv, pin;
	logic [32:0] q[$];
	logic [15:0] v;
	logic [1:0] e;
	logic [11:0] ofs[2] = '{12'h06c, 12'h084};
	int err_total, check_count;
	slled_strap_led #(.BLINK_CYCLES(4)) dut(.clk, .rst, .hwPowerDown, .portOneStatus(st1), .portTwoStatus(st2),
		.portOneLedAIn(pin[1]), .portOneLedAOut(drv[1]), .portOneLedAOe(oe[1]), .portOneLedBIn(pin[0]),
		.portOneLedBOut(drv[0]), .portOneLedBOe(oe[0]), .portTwoLedAIn(pin[2]), .portTwoLedAOut(drv[2]),
		.portTwoLedAOe(oe[2]), .portTwoLedBOut(p2b), .portTwoLedBOe(), .eepromPresentStrapIn(pin[3]),
		.eepromPresentStrapOut(drv[3]), .eepromPresentStrapOe(oe[3]), .bus8bit(b8), .bigEndian(be),
		.eepromPresent(ep), .reservedStrapLow(rl), .pinsAreOutputs(po), .psel, .penable, .pwrite, .paddr,
		.pwdata, .prdata, .pready, .pslverr);
	slled_board brd(.strap, .oe, .drv, .pin);
	function automatic logic [31:0] chip_configuration(input logic [3:0] s);
		return {21'h0, s[2], s[3], 1'b0, {2{s[1]}}, 5'h0, !s[0]};
	endfunction : chip_configuration
	task automatic chk(input logic [32:0] s, input logic [32:0] x);
		check_count++;
		if (s !== x) begin
			err_total++;
			$display("mismatch t=%0t seen=%h exp=%h", $time, s, x);
		end
	endtask : chk
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		@(posedge clk iff pready);
		psel <= 1'b0; penable <= 1'b0;
	endtask : apb
	task automatic rd(input logic [11:0] a, input logic [32:0] x);
		q.push_back(x);
		apb(1'b0, a, 32'h0);
	endtask : rd
	task automatic complete_run;
		$display("checks=%0d errors=%0d", check_count, err_total);
		if (err_total == 0 && check_count > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask : complete_run
	always @(posedge clk) if (psel && penable && pready && !pwrite) chk({pslverr, prdata}, q.pop_front());
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	initial begin
		#100000;
		err_total++;
		complete_run();
	end
	initial begin
		{rst, hwPowerDown, psel, penable, pwrite} = 5'h10;
		paddr = 12'h0; pwdata = 32'h0; st1 = 4'h0; st2 = 4'h0; strap = 4'hf;
		err_total = 0; check_count = 0;
		void'($urandom(32'h09511f0f));
		for (int i = 0; i < 4; i++) begin
			strap <= 4'($urandom) | 4'h1;
			hwPowerDown <= i[0];
			rst <= !i[0];
			repeat (8) @(posedge clk);
			{rst, hwPowerDown} <= 2'h0;
			repeat (4) @(posedge clk);
			rd(12'h100, {1'b0, chip_configuration(strap)});
			chk(33'({b8, be, ep, rl}), 33'({~strap[1], ~strap[2], strap[3], ~strap[0]}));
		end
		for (int p = 0; p < 2; p++) for (int k = 0; k < 8; k++) begin
			v = {1'b0, k[2:0], 10'h0, 2'($urandom)};
			apb(1'b1, ofs[p], {16'hffff, v});
			rd(ofs[p], {17'h0, v});
			st1 <= 4'($urandom) & 4'hb;
			st2 <= 4'($urandom) & 4'hb;
			repeat (2) @(posedge clk);
			e = k ? {~v[0], ~v[1]} : p ? {~(st2.speed100 & st2.link), ~(st1.fullDuplex & st1.link)} :
				{~(st1.speed100 & st1.link), ~st1.link};
			chk(33'(p ? {drv[2], p2b} : {drv[1], drv[0]}), 33'(e));
		end
		rd(12'h0f0, 33'h100000000);
		rd(12'h104, {9'h0, st2, st1});
		apb(1'b1, 12'h108, 32'h1);
		rd(12'h108, 33'h1);
		repeat (2) @(posedge clk);
		chk(33'({po, oe[1], drv[1]}), 33'h1);
		apb(1'b1, 12'h108, 32'h0);
		repeat (3) @(posedge clk);
		chk(33'({po, oe[1]}), 33'h3);
		strap <= strap ^ 4'he;
		apb(1'b1, 12'h100, 32'h0);
		rd(12'h100, {1'b0, chip_configuration(strap ^ 4'he)});
		repeat (3) @(posedge clk);
		complete_run();
	end
endmodule : tb_top
